// >>> shared/pwo_pkg.sv
package pwo_pkg;

  localparam int unsigned NUM_OUT = 6;
  localparam int unsigned NUM_PAIR = 3;
  localparam int unsigned DT_W = 6;
  localparam int unsigned EN_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_CTL0 = 8'h08;
  localparam logic [7:0] OFS_CTL1 = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // field positions
  localparam int unsigned CTL0_EN_LSB = 0;
  localparam int unsigned CTL0_IND_LSB = 3;
  localparam int unsigned CTL1_SYNC_BIT = 0;
  localparam int unsigned CTL1_DT_LSB = 8;
  localparam int unsigned STAT_HIGH_SIDE_POLARITY_BIT = 6;
  localparam int unsigned STAT_LOW_SIDE_POLARITY_BIT = 7;
  localparam int unsigned STAT_RPF_BIT = 8;

  // reset values
  localparam logic [5:0] SEL_RST = 6'h3f;
  localparam logic [5:0] STATE_RST = 6'h00;
  localparam logic [2:0] IND_RST = 3'h0;
  localparam logic [5:0] DT_RST = 6'h00;

  // output pin enable field codes
  localparam logic [2:0] EN_OFF = 3'h0;
  localparam logic [2:0] EN_P0 = 3'h1;
  localparam logic [2:0] EN_P01 = 3'h2;
  localparam logic [2:0] EN_ODD = 3'h3;
  localparam logic [2:0] EN_ALL = 3'h4;

  localparam logic [5:0] MASK_P0 = 6'h03;
  localparam logic [5:0] MASK_P01 = 6'h0f;
  localparam logic [5:0] MASK_ODD = 6'h2a;
  localparam logic [5:0] MASK_ALL = 6'h3f;

endpackage

// >>> verilog/pwo_rst_sync.sv
`timescale 1ns/1ps
module pwo_rst_sync (
  // clock and raw reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // released reset
  output logic rst_n
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign rst_n = sync_q;

endmodule

// >>> verilog/pwo_dead_band.sv
`timescale 1ns/1ps
module pwo_dead_band #(
  parameter int unsigned DT_W = 6
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pair control
  input wire logic comp,
  input wire logic [DT_W-1:0] dt,
  // requested levels, active high
  input wire logic odd_req,
  input wire logic even_req,
  // gated levels
  output logic odd_o,
  output logic even_o
);

  if (DT_W < 1) begin : g_chk_dt
    $error("DT_W must be at least one");
  end

  logic cur_q;
  logic [DT_W-1:0] cnt_q;

  // odd level change restarts the dead band
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= 1'b0;
      cnt_q <= '0;
    end else if (odd_req != cur_q) begin
      cur_q <= odd_req;
      cnt_q <= dt;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // complementary: even is the gated complement of odd
  always_comb begin
    if (comp) begin
      odd_o = cur_q & (cnt_q == '0);
      even_o = ~cur_q & (cnt_q == '0);
    end else begin
      odd_o = odd_req;
      even_o = even_req;
    end
  end

  no_overlap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    comp |-> !(odd_o && even_o))
    else $error("both outputs of a complementary pair active");

  dead_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    comp && (odd_req != cur_q) && (dt != '0) |=> !odd_o && !even_o)
    else $error("no dead band after odd level change");

endmodule

// >>> verilog/pwo_top.sv
`timescale 1ns/1ps
module pwo_top #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned TB_W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration straps
  input wire logic cfg_high_side_polarity,
  input wire logic cfg_low_side_polarity,
  input wire logic cfg_reset_pin_function_select,
  // duty comparison and time base
  input wire logic [5:0] pwm_raw,
  input wire logic [TB_W-1:0] timebase_counter,
  input wire logic [TB_W-1:0] timebase_period,
  input wire logic center_aligned,
  // general purpose port latches
  input wire logic [5:0] port_data_latch,
  input wire logic [5:0] pin_direction_latch,
  // pins
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe
);

  if (ADDR_W < 5) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end
  if (TB_W < 1) begin : g_chk_tb
    $error("TB_W must be at least one");
  end

  ////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [5:0] en_decode(input logic [2:0] f);
    logic [5:0] m;
    m = '0;
    if (f == pwo_pkg::EN_P0) begin
      m = pwo_pkg::MASK_P0;
    end else if (f == pwo_pkg::EN_P01) begin
      m = pwo_pkg::MASK_P01;
    end else if (f == pwo_pkg::EN_ODD) begin
      m = pwo_pkg::MASK_ODD;
    end else if (f >= pwo_pkg::EN_ALL) begin
      m = pwo_pkg::MASK_ALL;
    end
    return m;
  endfunction

  function automatic logic [5:0] pol_mask(input logic hp, input logic lp);
    return {3{hp, lp}};
  endfunction

  function automatic logic [ADDR_W-1:0] ofs(input logic [7:0] o);
    return ADDR_W'(o);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // reset

  logic rst_n;

  pwo_rst_sync u_rst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .rst_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////
  // straps

  logic init_q;
  logic high_side_polarity_q;
  logic low_side_polarity_q;
  logic rpf_q;

  // straps taken once, on the first edge after release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b1;
      high_side_polarity_q <= 1'b0;
      low_side_polarity_q <= 1'b0;
      rpf_q <= 1'b1;
    end else if (init_q) begin
      init_q <= 1'b0;
      high_side_polarity_q <= cfg_high_side_polarity;
      low_side_polarity_q <= cfg_low_side_polarity;
      rpf_q <= cfg_reset_pin_function_select;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb decode

  logic wr_en;
  logic setup;
  logic hit;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic [5:0] sel_q;
  logic [5:0] st_q;
  logic [2:0] en_q;
  logic [2:0] ind_q;
  logic sync_en_q;
  logic [5:0] dt_q;
  logic [5:0] dt_out;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;

  always_comb begin
    rdata_d = '0;
    hit = 1'b1;
    if (paddr == ofs(pwo_pkg::OFS_SEL)) begin
      rdata_d[5:0] = sel_q;
    end else if (paddr == ofs(pwo_pkg::OFS_STATE)) begin
      rdata_d[5:0] = st_q;
    end else if (paddr == ofs(pwo_pkg::OFS_CTL0)) begin
      rdata_d[pwo_pkg::CTL0_EN_LSB +: pwo_pkg::EN_W] = en_q;
      rdata_d[pwo_pkg::CTL0_IND_LSB +: pwo_pkg::NUM_PAIR] = ind_q;
    end else if (paddr == ofs(pwo_pkg::OFS_CTL1)) begin
      rdata_d[pwo_pkg::CTL1_SYNC_BIT] = sync_en_q;
      rdata_d[pwo_pkg::CTL1_DT_LSB +: pwo_pkg::DT_W] = dt_q;
    end else if (paddr == ofs(pwo_pkg::OFS_STAT)) begin
      rdata_d[5:0] = pin_o;
      rdata_d[pwo_pkg::STAT_HIGH_SIDE_POLARITY_BIT] = high_side_polarity_q;
      rdata_d[pwo_pkg::STAT_LOW_SIDE_POLARITY_BIT] = low_side_polarity_q;
      rdata_d[pwo_pkg::STAT_RPF_BIT] = rpf_q;
    end else begin
      hit = 1'b0;
    end
  end

  // read data prepared in the setup cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= pwo_pkg::SEL_RST;
      st_q <= pwo_pkg::STATE_RST;
    end else if (wr_en && paddr == ofs(pwo_pkg::OFS_SEL)) begin
      sel_q <= pwdata[5:0];
    end else if (wr_en && paddr == ofs(pwo_pkg::OFS_STATE)) begin
      st_q <= pwdata[5:0];
    end
  end

  // pin enable field: cleared by reset, then strap decides
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= pwo_pkg::EN_OFF;
      ind_q <= pwo_pkg::IND_RST;
    end else if (init_q) begin
      en_q <= cfg_reset_pin_function_select ? pwo_pkg::EN_OFF : pwo_pkg::EN_ALL;
    end else if (wr_en && paddr == ofs(pwo_pkg::OFS_CTL0)) begin
      en_q <= pwdata[pwo_pkg::CTL0_EN_LSB +: pwo_pkg::EN_W];
      ind_q <= pwdata[pwo_pkg::CTL0_IND_LSB +: pwo_pkg::NUM_PAIR];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_en_q <= 1'b0;
      dt_q <= pwo_pkg::DT_RST;
    end else if (wr_en && paddr == ofs(pwo_pkg::OFS_CTL1)) begin
      sync_en_q <= pwdata[pwo_pkg::CTL1_SYNC_BIT];
      dt_q <= pwdata[pwo_pkg::CTL1_DT_LSB +: pwo_pkg::DT_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // override synchronisation

  logic sync_pt;
  logic [5:0] sel_act_q;
  logic [5:0] st_act_q;

  assign sync_pt = (timebase_counter == '0) |
    (center_aligned & (timebase_counter == timebase_period));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_act_q <= pwo_pkg::SEL_RST;
      st_act_q <= pwo_pkg::STATE_RST;
    end else if (!sync_en_q || sync_pt) begin
      sel_act_q <= sel_q;
      st_act_q <= st_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output path

  logic [5:0] lvl;
  logic [5:0] pin_en;
  logic [5:0] pol_out;
  logic [5:0] pin_o_q;
  logic [5:0] pin_oe_q;

  // select one: duty comparison, zero: manual bit
  assign lvl = (sel_act_q & pwm_raw) | (~sel_act_q & st_act_q);

  for (genvar p = 0; p < pwo_pkg::NUM_PAIR; p++) begin : g_pair
    pwo_dead_band #(
      .DT_W(pwo_pkg::DT_W)
    ) u_db (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .comp(~ind_q[p]),
      .dt(dt_q),
      .odd_req(lvl[2*p+1]),
      .even_req(lvl[2*p]),
      .odd_o(dt_out[2*p+1]),
      .even_o(dt_out[2*p])
    );
  end

  assign pin_en = en_decode(en_q);
  assign pol_out = dt_out ^ pol_mask(high_side_polarity_q, low_side_polarity_q);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
    end else begin
      for (int i = 0; i < pwo_pkg::NUM_OUT; i++) begin
        if (pin_en[i]) begin
          pin_o_q[i] <= pol_out[i];
          pin_oe_q[i] <= 1'b1;
        end else begin
          pin_o_q[i] <= port_data_latch[i];
          pin_oe_q[i] <= ~pin_direction_latch[i];
        end
      end
    end
  end

  assign pin_o = pin_o_q;
  assign pin_oe = pin_oe_q;

  ////////////////////////////////////////////////////////////////////
  // checks

  sel_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    setup && paddr == ofs(pwo_pkg::OFS_SEL) |=> prdata[31:6] == '0 && prdata[5:0] == $past(sel_q))
    else $error("override select readback wrong");

  sync_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_en_q && !sync_pt |=> $stable(sel_act_q) && $stable(st_act_q))
    else $error("override applied outside a sync point");

  edge_apply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_en_q && timebase_counter == '0 |=> sel_act_q == $past(sel_q))
    else $error("override not applied at counter zero");

  center_apply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_en_q && center_aligned && timebase_counter == timebase_period
    |=> st_act_q == $past(st_q))
    else $error("override not applied at period match");

  async_apply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sync_en_q |=> sel_act_q == $past(sel_q) && st_act_q == $past(st_q))
    else $error("override not applied at once");

  strap_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    init_q && !cfg_reset_pin_function_select |=> en_q == pwo_pkg::EN_ALL)
    else $error("pin enable field not loaded from strap");

  strap_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    init_q && cfg_reset_pin_function_select |=> en_q == pwo_pkg::EN_OFF ##1 pin_oe == ~$past(pin_direction_latch))
    else $error("pin enable field not cleared at reset");

  pin_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_en == pwo_pkg::MASK_ALL |=> pin_oe == 6'h3f && pin_o == $past(pol_out))
    else $error("enabled pin not driven by pwm path");

  odd_pol_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_en[1] && !init_q |=> pin_o[1] == ($past(dt_out[1]) ^ high_side_polarity_q))
    else $error("high side polarity wrong");

  even_pol_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_en[0] && !init_q |=> pin_o[0] == ($past(dt_out[0]) ^ low_side_polarity_q))
    else $error("low side polarity wrong");

  manual_lvl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ind_q[0] && !sel_act_q[1] && pin_en[1] && !init_q
    |=> pin_o[1] == ($past(st_act_q[1]) ^ high_side_polarity_q))
    else $error("manual output bit not obeyed");

  latch_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pin_en[0] |=> pin_o[0] == $past(port_data_latch[0])
    && pin_oe[0] == !$past(pin_direction_latch[0]))
    else $error("disabled pin not under port latch control");

  sel_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_en && paddr == ofs(pwo_pkg::OFS_SEL) |=> sel_q == $past(pwdata[5:0]))
    else $error("override select write lost");

  state_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_en && paddr == ofs(pwo_pkg::OFS_STATE) |=> st_q == $past(pwdata[5:0]))
    else $error("manual output write lost");

endmodule

// >>> verification/pwo_inverter_model.sv
`timescale 1ns/1ps
module pwo_inverter_model (
  // pin side
  input wire logic clk_sys,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe,
  // gate polarity and pair mode
  input wire logic high_side_polarity,
  input wire logic low_side_polarity,
  input wire logic [2:0] comp_mask,
  // shoot-through events seen
  output int shoot_cnt
);
  logic [5:0] gate_on;
  int k;
  // a transistor conducts while its pin sits at the active level
  assign gate_on = pin_oe & (pin_o ^ {3{high_side_polarity, low_side_polarity}});
  initial shoot_cnt = 0;
  // both transistors of a complementary leg on together is a short
  always @(posedge clk_sys) begin
    for (k = 0; k < 3; k++) begin
      if (comp_mask[k] && gate_on[2*k] === 1'b1 && gate_on[2*k+1] === 1'b1) begin
        shoot_cnt = shoot_cnt + 1;
      end
    end
  end
endmodule

// >>> verification/pwm_output_override_polarity_bench.sv
`timescale 1ns/1ps
module pwm_output_override_polarity_bench;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic high_side_polarity, low_side_polarity, rpf, center_aligned;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pwm_raw, port_data_latch, pin_direction_latch, pin_o, pin_oe;
  logic [11:0] timebase_counter, timebase_period;
  logic [2:0] comp_mask;
  int n_mismatch, check_count, shoot_cnt;
  logic [2:0] codes [5] = '{pwo_pkg::EN_OFF, pwo_pkg::EN_P0, pwo_pkg::EN_P01,
    pwo_pkg::EN_ODD, pwo_pkg::EN_ALL};
  logic [5:0] masks [5] = '{6'h00, pwo_pkg::MASK_P0, pwo_pkg::MASK_P01,
    pwo_pkg::MASK_ODD, pwo_pkg::MASK_ALL};

  pwo_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_high_side_polarity(high_side_polarity), .cfg_low_side_polarity(low_side_polarity),
    .cfg_reset_pin_function_select(rpf), .pwm_raw(pwm_raw),
    .timebase_counter(timebase_counter), .timebase_period(timebase_period),
    .center_aligned(center_aligned), .port_data_latch(port_data_latch),
    .pin_direction_latch(pin_direction_latch), .pin_o(pin_o), .pin_oe(pin_oe));

  pwo_inverter_model inv (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe), .high_side_polarity(high_side_polarity),
    .low_side_polarity(low_side_polarity), .comp_mask(comp_mask), .shoot_cnt(shoot_cnt));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      print_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  task automatic do_reset(input logic h, input logic l, input logic r);
    arst_n <= 1'b0;
    high_side_polarity <= h;
    low_side_polarity <= l;
    rpf <= r;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  // compare pins in mid-cycle, then return on the next rising edge
  task automatic pins(input logic [5:0] eo, input logic [5:0] eoe);
    @(negedge clk_sys);
    check({26'h0, pin_o}, {26'h0, eo});
    check({26'h0, pin_oe}, {26'h0, eoe});
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset_regs();
    apb(1'b0, pwo_pkg::OFS_SEL, 32'h0);
    check(rd, 32'h3f);
    apb(1'b0, pwo_pkg::OFS_STATE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, pwo_pkg::OFS_CTL0, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, pwo_pkg::EN_OFF});
    apb(1'b0, pwo_pkg::OFS_STAT, 32'h0);
    check({29'h0, rd[8:6]}, 32'h4);
    pins(6'h2d, 6'h30);
    apb(1'b1, pwo_pkg::OFS_SEL, 32'hff);
    apb(1'b0, pwo_pkg::OFS_SEL, 32'h0);
    check(rd, 32'h3f);
    apb(1'b1, pwo_pkg::OFS_STATE, 32'hff);
    apb(1'b0, pwo_pkg::OFS_STATE, 32'h0);
    check(rd, 32'h3f);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, pwo_pkg::OFS_STATE, 32'h0);
  endtask

  task automatic s_enable();
    int c;
    logic [5:0] m;
    for (c = 0; c < 5; c++) begin
      m = masks[c];
      apb(1'b1, pwo_pkg::OFS_CTL0, {26'h0, 3'h7, codes[c]});
      repeat (3) @(posedge clk_sys);
      pins((pwm_raw & m) | (port_data_latch & ~m), m | (~pin_direction_latch & ~m));
    end
    apb(1'b1, pwo_pkg::OFS_SEL, 32'h0);
    repeat (3) @(posedge clk_sys);
    apb(1'b1, pwo_pkg::OFS_STATE, 32'h03);
    pins(6'h00, 6'h3f);
    pins(6'h03, 6'h3f);
  endtask

  task automatic s_pol(input logic h, input logic l, input logic [5:0] eo);
    do_reset(h, l, 1'b0);
    apb(1'b0, pwo_pkg::OFS_CTL0, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, pwo_pkg::EN_ALL});
    apb(1'b1, pwo_pkg::OFS_CTL0, 32'h3c);
    apb(1'b1, pwo_pkg::OFS_SEL, 32'h0);
    repeat (3) @(posedge clk_sys);
    pins(eo, 6'h3f);
  endtask

  task automatic comp_step(input logic [5:0] st, input logic [1:0] ep);
    int i, gap, both;
    gap = 0;
    both = 0;
    apb(1'b1, pwo_pkg::OFS_STATE, {26'h0, st});
    for (i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      if (pin_o[1:0] == 2'b00) gap++;
      if (pin_o[1:0] == 2'b11) both++;
    end
    check(gap, 3);
    check(both, 0);
    check({30'h0, pin_o[1:0]}, {30'h0, ep});
    @(posedge clk_sys);
  endtask

  task automatic s_comp();
    do_reset(1'b0, 1'b0, 1'b1);
    apb(1'b1, pwo_pkg::OFS_CTL0, 32'h4);
    apb(1'b1, pwo_pkg::OFS_CTL1, 32'h300);
    apb(1'b1, pwo_pkg::OFS_SEL, 32'h0);
    comp_mask <= 3'h7;
    repeat (8) @(posedge clk_sys);
    pins(6'h15, 6'h3f);
    comp_step(6'h03, 2'b10);
    comp_step(6'h01, 2'b01);
    comp_mask <= 3'h0;
  endtask

  // pulse the time base counter to a value for one cycle
  task automatic tb_pulse(input logic [11:0] v);
    timebase_counter <= v;
    @(posedge clk_sys);
    timebase_counter <= 12'd5;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic s_sync();
    apb(1'b1, pwo_pkg::OFS_CTL0, 32'h3c);
    apb(1'b1, pwo_pkg::OFS_STATE, 32'h0);
    apb(1'b1, pwo_pkg::OFS_CTL1, 32'h1);
    repeat (3) @(posedge clk_sys);
    apb(1'b1, pwo_pkg::OFS_STATE, 32'h0f);
    tb_pulse(12'd9);
    pins(6'h00, 6'h3f);
    tb_pulse(12'd0);
    pins(6'h0f, 6'h3f);
    center_aligned <= 1'b1;
    apb(1'b1, pwo_pkg::OFS_STATE, 32'h30);
    repeat (4) @(posedge clk_sys);
    pins(6'h0f, 6'h3f);
    tb_pulse(12'd9);
    pins(6'h30, 6'h3f);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    arst_n = 1'b0;
    high_side_polarity = 1'b0;
    low_side_polarity = 1'b0;
    rpf = 1'b1;
    pwm_raw = 6'h15;
    timebase_counter = 12'd5;
    timebase_period = 12'd9;
    center_aligned = 1'b0;
    port_data_latch = 6'h2d;
    pin_direction_latch = 6'h0f;
    comp_mask = 3'h0;
    n_mismatch = 0;
    check_count = 0;
    do_reset(1'b0, 1'b0, 1'b1);
    s_reset_regs();
    s_enable();
    s_pol(1'b1, 1'b0, 6'h2a);
    s_pol(1'b0, 1'b1, 6'h15);
    s_comp();
    s_sync();
    check(shoot_cnt, 0);
    print_verdict();
  end
endmodule
